// >>> logic/ftl_regs.vh
// ftl_regs.vh: register map, fields and codes of the clear/limit block
// assumes: included by the block top only, bus address in bytes
`ifndef FTL_REGS_VH
`define FTL_REGS_VH
`define FTL_ADDR_W      5
`define FTL_DATA_W      32
`define FTL_FAULT_W     8
`define FTL_OFS_CONFIG  5'h00
`define FTL_OFS_STATUS  5'h04
`define FTL_OFS_IRQ_ST  5'h08
`define FTL_OFS_IRQ_CLR 5'h0c
`define FTL_OFS_IRQ_EN  5'h10
`define FTL_OFS_FAULT   5'h14
`define FTL_POL_LSB     0
`define FTL_POL_MSB     1
`define FTL_LIM_LSB     8
`define FTL_LIM_MSB     12
`define FTL_POL_RST     2'h3
`define FTL_LIM_RST     5'h03
`define FTL_POL_FALL    2'h1
`define FTL_POL_RISE    2'h2
`define FTL_LIM_AB_CL1  5'h01
`define FTL_LIM_AB_OP2  5'h02
`define FTL_LIM_AB_CL4  5'h04
`define FTL_LIM_AB_OP5  5'h05
`define FTL_LIM_ACW_CL  5'h07
`define FTL_LIM_ACW_OP  5'h08
`define FTL_LIM_BCCW_CL 5'h09
`define FTL_LIM_BCCW_OP 5'h0a
`define FTL_LIM_BA_CL   5'h0b
`define FTL_LIM_BA_OP   5'h0c
`define FTL_LIM_BCW_CL  5'h11
`define FTL_LIM_BCW_OP  5'h12
`define FTL_LIM_ACCW_CL 5'h13
`define FTL_LIM_ACCW_OP 5'h14
`define FTL_IRQ_W       3
`define FTL_IRQ_CLR_EV  0
`define FTL_IRQ_CW      1
`define FTL_IRQ_CCW     2
`define FTL_ST_W        5
`define FTL_ST_CW       0
`define FTL_ST_CCW      1
`define FTL_ST_CLR_LVL  2
`define FTL_ST_A_LVL    3
`define FTL_ST_B_LVL    4
`define FTL_PIN_W       3
`define FTL_PIN_CLR     0
`define FTL_PIN_A       1
`define FTL_PIN_B       2
`define FTL_PIN_RST     3'h7
`define FTL_ARM_CNT     2'h3
`define FTL_ARM_ONE     2'h1
`endif

// >>> logic/ftl_top.v
// ftl_top.v: alarm clear input and travel limit inputs of the drive
// assumes: pins are asynchronous to mclk; fault events and bus on mclk
`timescale 1ns/1ps
`default_nettype none
`include "ftl_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - mode 1: open-to-closed edge clears alarms
// R2 - only clear input edges clear, never levels
// R3 - mode 1: closed-to-open edge does nothing
// R4 - mode 2: closed-to-open edge clears alarms
// R5 - mode 2: open-to-closed edge does nothing
// R6 - mode 1: controller idles clear input open
// R7 - mode 2: controller idles clear input closed
// R8 - selector 1/4: A cw, B ccw, closed
// R9 - selector 2/5: A cw, B ccw, open
// R10 - active limit stops direction, sets warning
// R11 - selector 3/6/13/16: both general purpose
// R12 - selector 7/8: A cw limit only
// R13 - selector 9/10: B ccw limit only
// R14 - selector 11: B cw, A ccw, closed
// R15 - selector 12: B cw, A ccw, open
// R16 - selector 17/18: B cw limit only
// R17 - selector 19/20: A ccw limit only
// R18 - polarity 3: clear input general purpose
// R19 - synchronise inputs, edge compare, single pulse
module ftl_top
(
  input  wire                     mclk,
  input  wire                     reset_n,
  input  wire [`FTL_ADDR_W-1:0]   avs_address,
  input  wire                     avs_read,
  input  wire                     avs_write,
  input  wire [`FTL_DATA_W-1:0]   avs_writedata,
  output reg  [`FTL_DATA_W-1:0]   avs_readdata,
  output reg                      avs_waitrequest,
  input  wire                     alarm_clear_input,
  input  wire                     limit_input_a,
  input  wire                     limit_input_b,
  input  wire [`FTL_FAULT_W-1:0]  fault_event,
  output reg  [`FTL_FAULT_W-1:0]  fault_pending,
  output reg                      alarm_clear_pulse,
  output reg                      cw_stop,
  output reg                      ccw_stop,
  output reg                      cw_limit_warning,
  output reg                      ccw_limit_warning,
  output reg  [`FTL_PIN_W-1:0]    gp_input,
  output reg                      irq
);

////////////////////////////////////////////////////////////////////////////////
// state

reg  [1:0]                clear_polarity_selector;
reg  [4:0]                limit_selector;
reg  [`FTL_PIN_W-1:0]     pin_meta;
reg  [`FTL_PIN_W-1:0]     pin_sync;
reg                       clear_prev;
reg  [1:0]                arm_cnt;
reg  [`FTL_IRQ_W-1:0]     irq_status;
reg  [`FTL_IRQ_W-1:0]     irq_enable;

reg                       next_clear_pulse;
reg                       next_cw_stop;
reg                       next_ccw_stop;
reg  [`FTL_DATA_W-1:0]    next_readdata;
reg  [`FTL_IRQ_W-1:0]     next_irq_status;
reg  [`FTL_IRQ_W-1:0]     next_irq_enable;
reg  [`FTL_FAULT_W-1:0]   next_fault_pending;
reg                       next_cw_warning;
reg                       next_ccw_warning;

wire                      clear_now;
wire                      a_closed;
wire                      b_closed;
wire                      armed;
wire                      clear_fall;
wire                      clear_rise;
wire                      bus_req;
wire                      wr_take;
wire                      rd_latch;
wire                      wr_config;
wire                      wr_irq_clr;
wire                      wr_irq_en;
wire [`FTL_IRQ_W-1:0]     irq_event;
wire [`FTL_IRQ_W-1:0]     irq_clr_mask;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and clear edge detection

// open pin reads high, so closed is low
assign clear_now  = pin_sync[`FTL_PIN_CLR];
assign a_closed   = ~pin_sync[`FTL_PIN_A];
assign b_closed   = ~pin_sync[`FTL_PIN_B];

// edges are ignored until the compare stage holds real samples,
// so the reset value of the flops never fakes a clear
assign armed      = (arm_cnt == `FTL_ARM_CNT);
assign clear_fall = armed & clear_prev & ~clear_now; // R19
assign clear_rise = armed & ~clear_prev & clear_now; // R19

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    pin_meta   <= `FTL_PIN_RST;
    pin_sync   <= `FTL_PIN_RST;
    clear_prev <= 1'b1;
    arm_cnt    <= 2'h0;
  end
  else
  begin
    pin_meta   <= {limit_input_b, limit_input_a, alarm_clear_input}; // R19
    pin_sync   <= pin_meta; // R19
    clear_prev <= clear_now; // R19
    if (!armed)
    begin
      arm_cnt <= arm_cnt + `FTL_ARM_ONE;
    end
  end
end

// a steady level never produces a pulse, only a compare mismatch
always @*
begin
  next_clear_pulse = 1'b0;
  case (clear_polarity_selector)
    `FTL_POL_FALL:
    begin
      next_clear_pulse = clear_fall; // R1 R2 R3
    end
    `FTL_POL_RISE:
    begin
      next_clear_pulse = clear_rise; // R4 R2 R5
    end
    default:
    begin
      next_clear_pulse = 1'b0; // R18
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// limit mapping

// unlisted selector codes fall back to general purpose
always @*
begin
  next_cw_stop  = 1'b0;
  next_ccw_stop = 1'b0;
  case (limit_selector)
    `FTL_LIM_AB_CL1, `FTL_LIM_AB_CL4:
    begin
      next_cw_stop  = a_closed; // R8
      next_ccw_stop = b_closed; // R8
    end
    `FTL_LIM_AB_OP2, `FTL_LIM_AB_OP5:
    begin
      next_cw_stop  = ~a_closed; // R9
      next_ccw_stop = ~b_closed; // R9
    end
    `FTL_LIM_ACW_CL:
    begin
      next_cw_stop  = a_closed; // R12
    end
    `FTL_LIM_ACW_OP:
    begin
      next_cw_stop  = ~a_closed; // R12
    end
    `FTL_LIM_BCCW_CL:
    begin
      next_ccw_stop = b_closed; // R13
    end
    `FTL_LIM_BCCW_OP:
    begin
      next_ccw_stop = ~b_closed; // R13
    end
    `FTL_LIM_BA_CL:
    begin
      next_cw_stop  = b_closed; // R14
      next_ccw_stop = a_closed; // R14
    end
    `FTL_LIM_BA_OP:
    begin
      next_cw_stop  = ~b_closed; // R15
      next_ccw_stop = ~a_closed; // R15
    end
    `FTL_LIM_BCW_CL:
    begin
      next_cw_stop  = b_closed; // R16
    end
    `FTL_LIM_BCW_OP:
    begin
      next_cw_stop  = ~b_closed; // R16
    end
    `FTL_LIM_ACCW_CL:
    begin
      next_ccw_stop = a_closed; // R17
    end
    `FTL_LIM_ACCW_OP:
    begin
      next_ccw_stop = ~a_closed; // R17
    end
    default:
    begin
      next_cw_stop  = 1'b0; // R11
      next_ccw_stop = 1'b0; // R11
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// warnings and pending faults

// warnings hold after the switch releases until a clear;
// a new fault or active limit in the clear cycle wins
always @*
begin
  next_cw_warning    = next_cw_stop |
                       (cw_limit_warning & ~next_clear_pulse); // R10
  next_ccw_warning   = next_ccw_stop |
                       (ccw_limit_warning & ~next_clear_pulse); // R10
  next_fault_pending = fault_event |
                       (fault_pending & ~{`FTL_FAULT_W{next_clear_pulse}}); // R1 R4
end

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    alarm_clear_pulse <= 1'b0;
    cw_stop           <= 1'b0;
    ccw_stop          <= 1'b0;
    cw_limit_warning  <= 1'b0;
    ccw_limit_warning <= 1'b0;
    fault_pending     <= {`FTL_FAULT_W{1'b0}};
    gp_input          <= `FTL_PIN_RST;
  end
  else
  begin
    alarm_clear_pulse <= next_clear_pulse; // R19
    cw_stop           <= next_cw_stop; // R10
    ccw_stop          <= next_ccw_stop; // R10
    cw_limit_warning  <= next_cw_warning;
    ccw_limit_warning <= next_ccw_warning;
    fault_pending     <= next_fault_pending;
    gp_input          <= pin_sync; // R11 R18
  end
end

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle, read data staged before release

assign bus_req    = avs_read | avs_write;
assign wr_take    = avs_write & ~avs_waitrequest;
assign rd_latch   = avs_read & avs_waitrequest;
assign wr_config  = wr_take & (avs_address == `FTL_OFS_CONFIG);
assign wr_irq_clr = wr_take & (avs_address == `FTL_OFS_IRQ_CLR);
assign wr_irq_en  = wr_take & (avs_address == `FTL_OFS_IRQ_EN);

always @*
begin
  next_readdata = {`FTL_DATA_W{1'b0}};
  case (avs_address)
    `FTL_OFS_CONFIG:
    begin
      next_readdata[`FTL_POL_MSB:`FTL_POL_LSB] = clear_polarity_selector;
      next_readdata[`FTL_LIM_MSB:`FTL_LIM_LSB] = limit_selector;
    end
    `FTL_OFS_STATUS:
    begin
      next_readdata[`FTL_ST_CW]      = cw_limit_warning;
      next_readdata[`FTL_ST_CCW]     = ccw_limit_warning;
      next_readdata[`FTL_ST_CLR_LVL] = pin_sync[`FTL_PIN_CLR];
      next_readdata[`FTL_ST_A_LVL]   = pin_sync[`FTL_PIN_A];
      next_readdata[`FTL_ST_B_LVL]   = pin_sync[`FTL_PIN_B];
    end
    `FTL_OFS_IRQ_ST:
    begin
      next_readdata[`FTL_IRQ_W-1:0] = irq_status;
    end
    `FTL_OFS_IRQ_EN:
    begin
      next_readdata[`FTL_IRQ_W-1:0] = irq_enable;
    end
    `FTL_OFS_FAULT:
    begin
      next_readdata[`FTL_FAULT_W-1:0] = fault_pending;
    end
    default:
    begin
      next_readdata = {`FTL_DATA_W{1'b0}};
    end
  endcase
end

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    avs_waitrequest         <= 1'b1;
    avs_readdata            <= {`FTL_DATA_W{1'b0}};
    clear_polarity_selector <= `FTL_POL_RST;
    limit_selector          <= `FTL_LIM_RST;
  end
  else
  begin
    if (!avs_waitrequest)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (bus_req)
    begin
      avs_waitrequest <= 1'b0;
    end
    if (rd_latch)
    begin
      avs_readdata <= next_readdata;
    end
    if (wr_config)
    begin
      clear_polarity_selector <= avs_writedata[`FTL_POL_MSB:`FTL_POL_LSB];
      limit_selector          <= avs_writedata[`FTL_LIM_MSB:`FTL_LIM_LSB];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: sticky events, write-one clear, enable mask

assign irq_event[`FTL_IRQ_CLR_EV] = next_clear_pulse;
assign irq_event[`FTL_IRQ_CW]     = next_cw_stop & ~cw_stop;
assign irq_event[`FTL_IRQ_CCW]    = next_ccw_stop & ~ccw_stop;
assign irq_clr_mask = wr_irq_clr ? avs_writedata[`FTL_IRQ_W-1:0]
                                 : {`FTL_IRQ_W{1'b0}};

// an event in the clear cycle survives the clear
always @*
begin
  next_irq_status = (irq_status & ~irq_clr_mask) | irq_event;
  next_irq_enable = irq_enable;
  if (wr_irq_en)
  begin
    next_irq_enable = avs_writedata[`FTL_IRQ_W-1:0];
  end
end

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    irq_status <= {`FTL_IRQ_W{1'b0}};
    irq_enable <= {`FTL_IRQ_W{1'b0}};
    irq        <= 1'b0;
  end
  else
  begin
    irq_status <= next_irq_status;
    irq_enable <= next_irq_enable;
    irq        <= |(next_irq_status & next_irq_enable);
  end
end

endmodule
`default_nettype wire

// >>> dv/ftl_top_assertions.sv
// ftl_top_assertions.sv: port checker for the clear/limit block
// assumes: bound into ftl_top, one mclk domain
`timescale 1ns/1ps
`default_nettype none
module ftl_chk
(
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] fault_event,
  input wire logic [7:0] fault_pending,
  input wire logic       alarm_clear_pulse,
  input wire logic       cw_stop,
  input wire logic       ccw_stop,
  input wire logic       cw_limit_warning,
  input wire logic       ccw_limit_warning,
  input wire logic [2:0] gp_input
);
  logic [3:0] hist;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // clear level history, so a pulse can be traced back to an edge
  always @(posedge mclk or negedge reset_n)
    if (!reset_n)
      hist <= 4'hf;
    else
      hist <= {hist[2:0], gp_input[0]};
  sequence s_pulse;
    alarm_clear_pulse;
  endsequence
  sequence s_edge_near;
    ##[0:2] (hist != 4'h0 && hist != 4'hf);
  endsequence
  a_pulse_single: assert property (s_pulse |=> !alarm_clear_pulse)
    else $error("clear pulse too long");
  a_pulse_edge: assert property (s_pulse |-> s_edge_near)
    else $error("clear pulse without edge");
  a_fault_drop: assert property (|($past(fault_pending) & ~fault_pending) |-> s_pulse)
    else $error("fault left without clear");
  a_pulse_faults: assert property (s_pulse |-> (fault_pending & ~$past(fault_event)) == 8'h00)
    else $error("fault kept over clear");
  a_fault_set: assert property (|fault_event |=> (fault_pending & $past(fault_event)) == $past(fault_event))
    else $error("fault event lost");
  a_cw_warn: assert property (cw_stop |-> cw_limit_warning)
    else $error("cw stop without warning");
  a_ccw_warn: assert property (ccw_stop |-> ccw_limit_warning)
    else $error("ccw stop without warning");
  a_warn_sticky: assert property ($fell(cw_limit_warning) |-> s_pulse)
    else $error("cw warning dropped");
  a_warn_cause: assert property ($rose(ccw_limit_warning) |-> ccw_stop)
    else $error("ccw warning without stop");
  a_pulse_warn: assert property ((alarm_clear_pulse && !cw_stop) |-> !cw_limit_warning)
    else $error("cw warning kept over clear");
endmodule
bind ftl_top ftl_chk u_ftl_chk (.mclk(mclk), .reset_n(reset_n), .fault_event(fault_event),
  .fault_pending(fault_pending), .alarm_clear_pulse(alarm_clear_pulse), .cw_stop(cw_stop),
  .ccw_stop(ccw_stop), .cw_limit_warning(cw_limit_warning),
  .ccw_limit_warning(ccw_limit_warning), .gp_input(gp_input));
`default_nettype wire

// >>> dv/ftl_switches.sv
// ftl_switches.sv: limit switch and host clear contact model
// assumes: bench calls drive, shares mclk
`timescale 1ns/1ps
`default_nettype none
module ftl_switches
(
  input  wire logic mclk,
  output var  logic alarm_clear_input,
  output var  logic limit_input_a,
  output var  logic limit_input_b
);
  // contacts open at power-up, pins high
  initial
    {alarm_clear_input, limit_input_a, limit_input_b} = 3'h7;
  // level held 6 cycles: covers sync and output stage
  task drive(input logic [2:0] v);
    @(posedge mclk);
    {alarm_clear_input, limit_input_a, limit_input_b} <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> dv/ftl_top_bench.sv
// ftl_top_bench.sv: self-checking bench of the clear/limit block
// assumes: ftl_top, ftl_switches and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module ftl_top_bench;
  logic        mclk;
  logic        reset_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        alarm_clear_input;
  logic        limit_input_a;
  logic        limit_input_b;
  logic [7:0]  fault_event;
  logic [7:0]  fault_pending;
  logic        alarm_clear_pulse;
  logic        cw_stop;
  logic        ccw_stop;
  logic        cw_limit_warning;
  logic        ccw_limit_warning;
  logic [2:0]  gp_input;
  logic        irq;
  logic [31:0] q;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          pulses = 0;
  ftl_top u_ftl_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .alarm_clear_input(alarm_clear_input), .limit_input_a(limit_input_a),
    .limit_input_b(limit_input_b), .fault_event(fault_event), .fault_pending(fault_pending),
    .alarm_clear_pulse(alarm_clear_pulse), .cw_stop(cw_stop), .ccw_stop(ccw_stop),
    .cw_limit_warning(cw_limit_warning), .ccw_limit_warning(ccw_limit_warning),
    .gp_input(gp_input), .irq(irq));
  ftl_switches u_ftl_switches (.mclk(mclk), .alarm_clear_input(alarm_clear_input),
    .limit_input_a(limit_input_a), .limit_input_b(limit_input_b));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (alarm_clear_pulse === 1'b1)
      pulses <= pulses + 1;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // no cycle count assumed: wait for waitrequest low, watchdog bounds it
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task fault(input logic [7:0] f);
    @(posedge mclk);
    fault_event <= f;
    @(posedge mclk);
    fault_event <= 8'h00;
    @(posedge mclk);
  endtask
  function automatic logic [1:0] lim_exp(input int s, input logic a, input logic b);
    case (s)
      1, 4:    return {~a, ~b};
      2, 5:    return {a, b};
      7:       return {~a, 1'b0};
      8:       return {a, 1'b0};
      9:       return {1'b0, ~b};
      10:      return {1'b0, b};
      11:      return {~b, ~a};
      12:      return {b, a};
      17:      return {~b, 1'b0};
      18:      return {b, 1'b0};
      19:      return {1'b0, ~a};
      20:      return {1'b0, a};
      default: return 2'b00;
    endcase
  endfunction
  task complete_run;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n       = 1'b0;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    fault_event   = 8'h00;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    chk(gp_input, 32'h7);
    repeat (6) @(posedge mclk);
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h303);
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h0);
    for (int s = 0; s <= 20; s++)
    begin
      bus(1'b1, 5'h00, {19'h0, s[4:0], 8'h03});
      for (int p = 0; p < 4; p++)
      begin
        u_ftl_switches.drive({1'b1, p[0], p[1]});
        chk({cw_stop, ccw_stop}, lim_exp(s, p[0], p[1]));
      end
    end
    bus(1'b1, 5'h00, 32'h303);
    u_ftl_switches.drive(3'h7);
    chk({cw_stop, ccw_stop, cw_limit_warning, ccw_limit_warning}, 32'h3);
    bus(1'b0, 5'h08, 32'h0);
    chk(q, 32'h6);
    fault(8'ha5);
    u_ftl_switches.drive(3'h3);
    chk(gp_input, 32'h6);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h1b);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'ha5);
    u_ftl_switches.drive(3'h7);
    chk({pulses[7:0], fault_pending}, 32'h00a5);
    bus(1'b1, 5'h0c, 32'h7);
    bus(1'b1, 5'h10, 32'h1);
    bus(1'b1, 5'h00, 32'h301);
    chk(irq, 32'h0);
    u_ftl_switches.drive(3'h3);
    chk({pulses[7:0], fault_pending, cw_limit_warning, irq}, 32'h401);
    fault(8'h3c);
    u_ftl_switches.drive(3'h7);
    chk({pulses[7:0], fault_pending}, 32'h013c);
    bus(1'b1, 5'h00, 32'h302);
    u_ftl_switches.drive(3'h3);
    chk({pulses[7:0], fault_pending}, 32'h013c);
    u_ftl_switches.drive(3'h7);
    repeat (10) @(posedge mclk);
    chk({pulses[7:0], fault_pending}, 32'h0200);
    bus(1'b1, 5'h0c, 32'h1);
    bus(1'b1, 5'h10, 32'h0);
    bus(1'b0, 5'h08, 32'h0);
    chk({q[0], irq}, 32'h0);
    u_ftl_switches.drive(3'h3);
    u_ftl_switches.drive(3'h7);
    bus(1'b0, 5'h08, 32'h0);
    chk({pulses[7:0], q[0], irq}, 32'he);
    complete_run;
  end
  // run needs about 800 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
